// ==== hdl/cocr_pkg.sv ====
package cocr_pkg;
  // Register offsets on the control port
  localparam logic [7:0] COCR_INPUT_SETUP_OFF = 8'h3C;
  localparam logic [7:0] COCR_GAIN_OFF        = 8'h3D;
  localparam logic [7:0] COCR_VOLUME_OFF      = 8'h3E;
  localparam logic [7:0] COCR_GAIN_TRIM_OFF   = 8'h3F;
  // Values after reset
  localparam logic [7:0] COCR_INPUT_SETUP_RST = 8'h10;
  localparam logic [7:0] COCR_GAIN_RST        = 8'h00;
  localparam logic [7:0] COCR_VOLUME_RST      = 8'hC9;
  localparam logic [7:0] COCR_GAIN_TRIM_RST   = 8'h80;
  // Field positions in the input setup register
  localparam int COCR_KIND_BIT      = 7;
  localparam int COCR_ARR_LSB       = 5;
  localparam int COCR_COUPLING_BIT  = 4;
  localparam int COCR_SWING_BIT     = 3;
  localparam int COCR_PROFILE_LSB   = 1;
  localparam int COCR_AUTO_GAIN_BIT = 0;
  // Field positions in gain and trim registers
  localparam int COCR_GAIN_LSB      = 2;
  localparam int COCR_GAIN_RSV1_BIT = 1;
  localparam int COCR_TRIM_LSB      = 4;
  // Gain code limit and volume figures (half-dB steps)
  localparam logic [5:0] COCR_GAIN_MAX_CODE = 6'h2A;
  localparam logic [7:0] COCR_VOL_UNITY     = 8'hC9;
  // Front-end profile codes
  typedef enum logic [1:0] {
    COCR_PROF_SNR  = 2'h0,
    COCR_PROF_BAD  = 2'h1,
    COCR_PROF_COMMON_MODE_REJECTION = 2'h2,
    COCR_PROF_RSV  = 2'h3
  } cocr_profile_t;
endpackage

// ==== hdl/cocr_regs.sv ====
`timescale 1ns/100ps
module cocr_regs (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Control port register access
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // Analog front end controls
  output logic             chan_one_input_kind,
  output logic      [1:0]  chan_one_input_arrangement,
  output logic             chan_one_coupling_sel,
  output logic             chan_one_swing_range,
  output cocr_pkg::cocr_profile_t chan_one_frontend_profile,
  output logic             chan_one_auto_gain_on,
  output logic      [5:0]  chan_one_analog_gain,
  output logic             chan_one_gain_reserved,
  output logic      [3:0]  chan_one_gain_trim,
  // Digital volume stage
  output logic      [7:0]  chan_one_volume_code,
  output logic             chan_one_mute,
  output logic signed [9:0] chan_one_volume_half_db
);
  import cocr_pkg::*;

  // Register state; every field below is decoded straight from these
  logic [7:0] setup_q;  // Input setup register
  logic [7:0] gain_q;   // Gain register
  logic [7:0] vol_q;    // Volume register
  logic [7:0] trim_q;   // Gain trim register
  logic [7:0] rdata_d;  // Read mux

  // Volume code to signed half-dB figure; linear between endpoints
  function automatic logic signed [9:0] vol_half_db(input logic [7:0] code);
    vol_half_db = $signed({2'b00, code}) - $signed({2'b00, COCR_VOL_UNITY});
  endfunction

  // Input setup register; all fields plain read/write
  always_ff @(posedge clock) begin
    if (srst) begin
      setup_q <= COCR_INPUT_SETUP_RST;
    end else if (reg_wr && reg_addr == COCR_INPUT_SETUP_OFF) begin
      setup_q <= reg_wdata;
    end
  end

  // Gain register; bit 0 is read-only and stays zero
  always_ff @(posedge clock) begin
    if (srst) begin
      gain_q <= COCR_GAIN_RST;
    end else if (reg_wr && reg_addr == COCR_GAIN_OFF) begin
      gain_q <= {reg_wdata[7:1], 1'b0};
    end
  end

  // Volume register
  always_ff @(posedge clock) begin
    if (srst) begin
      vol_q <= COCR_VOLUME_RST;
    end else if (reg_wr && reg_addr == COCR_VOLUME_OFF) begin
      vol_q <= reg_wdata;
    end
  end

  // Gain trim register; low nibble read-only zero
  always_ff @(posedge clock) begin
    if (srst) begin
      trim_q <= COCR_GAIN_TRIM_RST;
    end else if (reg_wr && reg_addr == COCR_GAIN_TRIM_OFF) begin
      trim_q <= {reg_wdata[7:4], 4'h0};
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      COCR_INPUT_SETUP_OFF: rdata_d = setup_q;
      COCR_GAIN_OFF:        rdata_d = gain_q;
      COCR_VOLUME_OFF:      rdata_d = vol_q;
      COCR_GAIN_TRIM_OFF:   rdata_d = trim_q;
      default:              rdata_d = 8'h00;
    endcase
  end

  // Read data is registered so it comes from flip-flops
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // Field decode to front end
  assign chan_one_input_kind        = setup_q[COCR_KIND_BIT];
  assign chan_one_input_arrangement = setup_q[COCR_ARR_LSB +: 2];
  assign chan_one_coupling_sel      = setup_q[COCR_COUPLING_BIT];
  assign chan_one_swing_range       = setup_q[COCR_SWING_BIT];
  assign chan_one_frontend_profile  = cocr_profile_t'(setup_q[COCR_PROFILE_LSB +: 2]);
  // Auto gain follows the bit; the AC-only restriction is left to software
  assign chan_one_auto_gain_on      = setup_q[COCR_AUTO_GAIN_BIT];
  // Gain code passes straight through, one dB per code
  assign chan_one_analog_gain       = gain_q[COCR_GAIN_LSB +: 6];
  assign chan_one_gain_reserved     = gain_q[COCR_GAIN_RSV1_BIT];
  assign chan_one_gain_trim         = trim_q[COCR_TRIM_LSB +: 4];
  assign chan_one_volume_code       = vol_q;
  // Code zero is a true mute, not the bottom of the scale
  assign chan_one_mute              = (vol_q == 8'h00);
  assign chan_one_volume_half_db    = vol_half_db(vol_q);

  // Assertions
  // A write strobe aimed at one register; shared by the write checks, the hold checks spell out their own
  sequence setup_write_s;
    reg_wr && reg_addr == 8'h3C;
  endsequence

  sequence gain_write_s;
    reg_wr && reg_addr == 8'h3D;
  endsequence

  sequence vol_write_s;
    reg_wr && reg_addr == 8'h3E;
  endsequence

  sequence trim_write_s;
    reg_wr && reg_addr == 8'h3F;
  endsequence

  // Address on the volume register in a quiet cycle, then one more quiet cycle
  sequence vol_read_s;
    !reg_wr && reg_addr == 8'h3E ##1 !reg_wr;
  endsequence

  // Reset values one edge after a reset cycle; DC coupling is the default
  reset_values_a: assert property (@(posedge clock)
      srst |=> setup_q == 8'h10 && gain_q == 8'h00 && vol_q == 8'hC9)
    else $error("registers not at reset value");

  // Trim register and read data also come back from reset
  trim_reset_a: assert property (@(posedge clock)
      srst |=> trim_q == 8'h80 && reg_rdata == 8'h00)
    else $error("trim or read data not at reset value");

  // Read-only gain bit never leaves zero
  gain_lsb_zero_a: assert property (@(posedge clock) disable iff (srst) gain_q[0] == 1'b0)
    else $error("gain bit 0 not zero");

  // Writable reserved gain bit keeps what was written
  gain_rsv_write_a: assert property (@(posedge clock) disable iff (srst)
      gain_write_s |=> chan_one_gain_reserved == $past(reg_wdata[1]))
    else $error("gain bit 1 write lost");

  // Whole setup byte is taken as written
  setup_write_a: assert property (@(posedge clock) disable iff (srst)
      setup_write_s |=> setup_q == $past(reg_wdata))
    else $error("setup write lost");

  // Each setup field lands on its own output; a swapped slice shows here
  setup_fields_a: assert property (@(posedge clock) disable iff (srst)
      setup_write_s |=> chan_one_input_kind == $past(reg_wdata[7])
        && chan_one_input_arrangement == $past(reg_wdata[6:5])
        && chan_one_coupling_sel == $past(reg_wdata[4])
        && chan_one_swing_range == $past(reg_wdata[3])
        && chan_one_frontend_profile == $past(reg_wdata[2:1])
        && chan_one_auto_gain_on == $past(reg_wdata[0]))
    else $error("setup field decode wrong");

  // Writes elsewhere leave the setup register alone
  setup_hold_a: assert property (@(posedge clock) disable iff (srst)
      reg_wr && reg_addr != 8'h3C |=> $stable(setup_q))
    else $error("setup changed by other write");

  // Volume byte is taken as written
  vol_write_a: assert property (@(posedge clock) disable iff (srst)
      vol_write_s |=> chan_one_volume_code == $past(reg_wdata))
    else $error("volume write lost");

  // Writes elsewhere leave the volume alone
  vol_hold_a: assert property (@(posedge clock) disable iff (srst)
      reg_wr && reg_addr != 8'h3E |=> $stable(vol_q))
    else $error("volume changed by other write");

  // Mute only for code zero
  mute_code_a: assert property (@(posedge clock) chan_one_mute == (chan_one_volume_code == 8'h00))
    else $error("mute decode wrong");

  // Bottom of the scale is -100 dB, that is -200 half-dB
  vol_scale_a: assert property (@(posedge clock)
      chan_one_volume_code == 8'h01 |-> chan_one_volume_half_db == -10'sd200)
    else $error("volume scale wrong");

  // One step above unity is one half-dB, so steps are linear through 0 dB
  vol_linear_a: assert property (@(posedge clock)
      chan_one_volume_code == 8'hCA |-> chan_one_volume_half_db == 10'sd1)
    else $error("volume step wrong");

  // Gain code follows the written bits one for one
  gain_step_a: assert property (@(posedge clock) disable iff (srst)
      gain_write_s |=> chan_one_analog_gain == $past(reg_wdata[7:2]))
    else $error("gain step wrong");

  // Writes elsewhere leave the gain alone
  other_hold_a: assert property (@(posedge clock) disable iff (srst)
      reg_wr && reg_addr != 8'h3D |=> $stable(gain_q))
    else $error("gain changed by other write");

  // Low trim nibble is read-only and stays zero
  trim_mask_a: assert property (@(posedge clock) disable iff (srst) trim_q[3:0] == 4'h0)
    else $error("trim low bits not zero");

  // Trim nibble is taken as written
  trim_write_a: assert property (@(posedge clock) disable iff (srst)
      trim_write_s |=> chan_one_gain_trim == $past(reg_wdata[7:4]))
    else $error("trim write lost");

  // Registered read shows the register one cycle after the address
  read_back_a: assert property (@(posedge clock) disable iff (srst)
      vol_read_s |-> reg_rdata == vol_q)
    else $error("read back wrong");

  // Addresses outside the bank read zero
  unmapped_read_a: assert property (@(posedge clock) disable iff (srst)
      !reg_wr && (reg_addr < 8'h3C || reg_addr > 8'h3F) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule

// ==== verification/cocr_regs_tb_top.sv ====
`timescale 1ns/100ps
module cocr_regs_tb_top;
  import cocr_pkg::*;
  // Stimulus, all driven at falling edge
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  // Observed outputs
  logic [7:0] rdata, vol;
  logic kind, cpl, swing, automatic_gain_control, rsv, mute;
  logic [1:0] arr;
  cocr_profile_t prof;
  logic [5:0] gain;
  logic [3:0] trim;
  logic signed [9:0] hdb;
  int num_errors = 0;
  int n_compared = 0;
  always #25 clock = ~clock;
  cocr_regs dut (.clock(clock), .srst(srst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(rdata), .chan_one_input_kind(kind), .chan_one_input_arrangement(arr),
    .chan_one_coupling_sel(cpl), .chan_one_swing_range(swing), .chan_one_frontend_profile(prof),
    .chan_one_auto_gain_on(automatic_gain_control), .chan_one_analog_gain(gain), .chan_one_gain_reserved(rsv),
    .chan_one_gain_trim(trim), .chan_one_volume_code(vol), .chan_one_mute(mute), .chan_one_volume_half_db(hdb));
  // Single compare, widened so one task fits every field
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock); reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    @(negedge clock); reg_wr = 1'b0;
  endtask
  // Read data is registered, so look one cycle after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clock); reg_addr = a;
    @(negedge clock); chk({2'h0, rdata}, {2'h0, e});
  endtask
  task automatic t_reset;
    rd(8'h3C, 8'h10);
    chk(swing, 0);
    rd(8'h3D, 8'h00);
    rd(8'h3E, 8'hC9);
    chk(hdb, 0);
    $display("reset test done");
  endtask
  // Profile codes 0, 2 and 3, every arrangement code, each bit both ways
  task automatic t_setup;
    logic [7:0] t [4] = '{8'hAD, 8'h54, 8'h66, 8'h10};
    foreach (t[i]) begin
      wr(8'h3C, t[i]);
      if (t[i][3]) begin
        wr(8'h3E, 8'hB5);
        chk(vol, 8'hB5);
      end
      chk(kind, t[i][7]);
      chk(arr, t[i][6:5]);
      chk(cpl, t[i][4]);
      chk(swing, t[i][3]);
      chk(prof, t[i][2:1]);
      chk(automatic_gain_control, t[i][0]);
      rd(8'h3C, t[i]);
    end
    $display("setup test done");
  endtask
  // Top gain code; reserved bit 1 written clear stays clear
  task automatic t_gain;
    wr(8'h3D, 8'hA8);
    chk(gain, 42);
    chk(rsv, 0);
    rd(8'h3D, 8'hA8);
    wr(8'h3D, 8'h04);
    chk(gain, 1);
    $display("gain test done");
  endtask
  task automatic t_vol;
    logic [7:0] c [6] = '{8'h00, 8'h01, 8'h02, 8'hC9, 8'hCA, 8'hFF};
    foreach (c[i]) begin
      wr(8'h3E, c[i]);
      chk(mute, c[i] == 8'h00);
      chk(vol, c[i]);
      if (c[i] != 8'h00) chk(hdb, {2'h0, c[i]} - 10'd201);
      rd(8'h3E, c[i]);
    end
    $display("volume test done");
  endtask
  // Unmapped writes must not disturb neighbours
  task automatic t_unmapped;
    wr(8'h3B, 8'hFF);
    wr(8'h40, 8'hFF);
    rd(8'h3B, 8'h00);
    rd(8'h3C, 8'h10);
    wr(8'h3F, 8'hFF);
    chk(trim, 4'hF);
    rd(8'h3F, 8'hF0);
    $display("unmapped test done");
  endtask
  // Reset in mid-run brings every register back
  task automatic t_rerst;
    wr(8'h3C, 8'h84);
    wr(8'h3F, 8'h30);
    @(negedge clock); srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    chk(kind, 0);
    chk(cpl, 1);
    chk(gain, 0);
    chk(vol, 8'hC9);
    chk(trim, 4'h8);
    rd(8'h3C, 8'h10);
    $display("mid-run reset test done");
  endtask
  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clock);
    srst = 1'b0;
    t_reset;
    t_setup;
    t_gain;
    t_vol;
    t_unmapped;
    t_rerst;
    summarize;
  end
  // Whole run needs well under 200 cycles
  initial begin
    repeat (2000) @(posedge clock);
    num_errors++;
    summarize;
  end
endmodule
